// ### src/mft_timer_map.svh
// Register map, field positions, reset values and timing counts of the timer chain
`ifndef MFT_TIMER_MAP_SVH
`define MFT_TIMER_MAP_SVH
`define MFT_OFS_CTRL_STATUS 4'h8
`define MFT_OFS_RIPPLE_COUNT 4'h9
`define MFT_OFS_WDOG_CFG 4'ha
`define MFT_OFS_WDOG_SERVICE 4'hb
`define MFT_BIT_OVF_FLAG 7
`define MFT_BIT_PER_FLAG 6
`define MFT_BIT_OVF_IRQEN 5
`define MFT_BIT_PER_IRQEN 4
`define MFT_BIT_OVF_CLR 3
`define MFT_BIT_PER_CLR 2
`define MFT_RST_RATE 2'h3
`define MFT_RST_CTRL 8'h03
`define MFT_POR_CYCLES 4064
`define MFT_STOP_SHORT_CYCLES 1024
`endif

// ### src/mft_timer_pkg.sv
// Types shared by the timer chain
package mft_timer_pkg;
    typedef enum logic [3:0] {
        MFT_POWERUP = 4'b0001,
        MFT_RUN = 4'b0010,
        MFT_STOPPED = 4'b0100,
        MFT_RECOVER = 4'b1000
    } mft_state_t;
endpackage

// ### src/mft_timer.sv
// Multi-function timer chain with Avalon-MM register slave
`timescale 1ns/1ns
`default_nettype none
`include "mft_timer_map.svh"
module mft_timer
    import mft_timer_pkg::*;
#(
    parameter int CHAIN_W = 20,
    parameter int POR_CYCLES = `MFT_POR_CYCLES,
    parameter int STOP_SHORT_CYCLES = `MFT_STOP_SHORT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic clkEn,
    // Avalon-MM slave
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Core side
    input wire logic stopReq,
    input wire logic stopExit,
    input wire logic stopLongDelay,
    output logic irqReq,
    output logic coreResetReq,
    // External reset pin, open drain
    input wire logic extResetPin_n,
    output logic extResetOut,
    output logic extResetOe_n
);

    // Delay counter must hold the longer of the two recovery counts
    localparam int DELAY_MAX = (POR_CYCLES > STOP_SHORT_CYCLES) ? POR_CYCLES : STOP_SHORT_CYCLES;
    localparam int POR_W = $clog2(DELAY_MAX + 1);

    logic extSync1_reg, extSync2_reg;
    logic [CHAIN_W-1:0] chain_reg;
    logic [2:0] wdog_reg;
    logic wdogEn_reg;
    logic ovfFlag_reg, perFlag_reg, ovfEn_reg, perEn_reg;
    logic [1:0] rate_reg;
    logic [POR_W-1:0] delay_reg;
    mft_state_t state_reg;
    logic ackPend_reg;
    logic wdogFire_reg;
    logic [31:0] readdata_next;

    function automatic logic tap_bit(input logic [CHAIN_W-1:0] c, input logic [1:0] sel);
        tap_bit = c[13 + sel];
    endfunction

    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction

    wire logic running = (state_reg == MFT_RUN);
    wire logic [CHAIN_W-1:0] chainInc = chain_reg + {{(CHAIN_W-1){1'b0}}, 1'b1};
    wire logic ovfEvent = running && (chain_reg[9:0] == 10'h3ff);
    wire logic tapRise = running && !tap_bit(chain_reg, rate_reg) && tap_bit(chainInc, rate_reg);
    wire logic wrStrobe = write && !ackPend_reg && clkEn;
    wire logic wrCtrl = wrStrobe && hit(address, `MFT_OFS_CTRL_STATUS);
    wire logic wdogService = wrStrobe && hit(address, `MFT_OFS_WDOG_SERVICE) && !writedata[0];
    wire logic wdogTimeout = running && wdogEn_reg && tapRise && (wdog_reg == 3'h7);
    wire logic stopEnter = running && stopReq;
    wire logic extReset = !extSync2_reg;

    // Pin synchroniser
    always_ff @(posedge clk) begin
        if (!rstn) begin
            extSync1_reg <= 1'b1;
            extSync2_reg <= 1'b1;
        end else if (clkEn) begin
            extSync1_reg <= extResetPin_n;
            extSync2_reg <= extSync1_reg;
        end
    end

    // Sequencing of power-up, run, stop and recovery
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= MFT_POWERUP;
            delay_reg <= '0;
        end else if (clkEn) begin
            case (state_reg)
                MFT_POWERUP: begin
                    delay_reg <= delay_reg + POR_W'(1);
                    if (delay_reg == POR_W'(POR_CYCLES - 1)) begin
                        state_reg <= MFT_RUN;
                        delay_reg <= '0;
                    end
                end
                MFT_RUN: begin
                    if (stopReq) begin
                        state_reg <= MFT_STOPPED;
                    end
                end
                MFT_STOPPED: begin
                    delay_reg <= '0;
                    if (stopExit) begin
                        state_reg <= MFT_RECOVER;
                    end
                end
                MFT_RECOVER: begin
                    delay_reg <= delay_reg + POR_W'(1);
                    if (delay_reg == (stopLongDelay ? POR_W'(POR_CYCLES - 1)
                                                   : POR_W'(STOP_SHORT_CYCLES - 1))) begin
                        state_reg <= MFT_RUN;
                        delay_reg <= '0;
                    end
                end
                default: begin
                    state_reg <= MFT_POWERUP;
                    delay_reg <= '0;
                end
            endcase
        end
    end

    // Divider chain; cleared on stop entry and held while in the stopped state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            chain_reg <= '0;
        end else if (clkEn) begin
            if (extReset || wdogTimeout || stopEnter) begin
                chain_reg <= '0;
            end else if ((state_reg == MFT_POWERUP || (state_reg == MFT_RECOVER && stopLongDelay)) &&
                         delay_reg == POR_W'(POR_CYCLES - 1)) begin
                chain_reg <= '0;
            end else if (state_reg == MFT_RECOVER && !stopLongDelay &&
                         delay_reg == POR_W'(STOP_SHORT_CYCLES - 1)) begin
                chain_reg <= '0;
            end else if (state_reg != MFT_STOPPED) begin
                chain_reg <= chainInc;
            end
        end
    end

    // Watchdog divide-by-eight stage
    always_ff @(posedge clk) begin
        if (!rstn) begin
            wdog_reg <= '0;
            wdogFire_reg <= 1'b0;
        end else if (clkEn) begin
            wdogFire_reg <= wdogTimeout;
            if (extReset || stopEnter || wdogService || wdogTimeout) begin
                wdog_reg <= '0;
            end else if (wdogEn_reg && tapRise) begin
                wdog_reg <= wdog_reg + 3'h1;
            end
        end
    end

    // Watchdog enable, configuration register
    always_ff @(posedge clk) begin
        if (!rstn || extReset || wdogFire_reg) begin
            wdogEn_reg <= 1'b1;
        end else if (wrStrobe && hit(address, `MFT_OFS_WDOG_CFG) && !writedata[0]) begin
            wdogEn_reg <= 1'b0;
        end
    end

    // Control and status register
    always_ff @(posedge clk) begin
        if (!rstn || extReset || wdogFire_reg) begin
            ovfFlag_reg <= 1'b0;
            perFlag_reg <= 1'b0;
            ovfEn_reg <= 1'b0;
            perEn_reg <= 1'b0;
            rate_reg <= `MFT_RST_RATE;
        end else if (clkEn) begin
            if (stopEnter) begin
                ovfFlag_reg <= 1'b0;
                perFlag_reg <= 1'b0;
                ovfEn_reg <= 1'b0;
                perEn_reg <= 1'b0;
            end else begin
                if (ovfEvent) begin
                    ovfFlag_reg <= 1'b1;
                end else if (wrCtrl && writedata[`MFT_BIT_OVF_CLR]) begin
                    ovfFlag_reg <= 1'b0;
                end
                if (tapRise) begin
                    perFlag_reg <= 1'b1;
                end else if (wrCtrl && writedata[`MFT_BIT_PER_CLR]) begin
                    perFlag_reg <= 1'b0;
                end
                if (wrCtrl) begin
                    ovfEn_reg <= writedata[`MFT_BIT_OVF_IRQEN];
                    perEn_reg <= writedata[`MFT_BIT_PER_IRQEN];
                    rate_reg <= writedata[1:0];
                end
            end
        end
    end

    // Read mux
    always_comb begin
        readdata_next = 32'h0;
        if (hit(address, `MFT_OFS_CTRL_STATUS)) begin
            readdata_next[`MFT_BIT_OVF_FLAG] = ovfFlag_reg;
            readdata_next[`MFT_BIT_PER_FLAG] = perFlag_reg;
            readdata_next[`MFT_BIT_OVF_IRQEN] = ovfEn_reg;
            readdata_next[`MFT_BIT_PER_IRQEN] = perEn_reg;
            readdata_next[1:0] = rate_reg;
        end else if (hit(address, `MFT_OFS_RIPPLE_COUNT)) begin
            readdata_next[7:0] = chain_reg[9:2];
        end else if (hit(address, `MFT_OFS_WDOG_CFG)) begin
            readdata_next[0] = wdogEn_reg;
        end
    end

    // Bus answer one cycle after the request
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ackPend_reg <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if (clkEn) begin
            ackPend_reg <= (read || write) && !ackPend_reg;
            waitrequest <= !((read || write) && !ackPend_reg);
            if (read && !ackPend_reg) begin
                readdata <= readdata_next;
            end
        end
    end

    // Interrupt and reset outputs
    always_ff @(posedge clk) begin
        if (!rstn) begin
            irqReq <= 1'b0;
            coreResetReq <= 1'b1;
            extResetOut <= 1'b0;
            extResetOe_n <= 1'b1;
        end else if (clkEn) begin
            irqReq <= (ovfFlag_reg && ovfEn_reg) || (perFlag_reg && perEn_reg);
            coreResetReq <= (state_reg == MFT_POWERUP) || wdogTimeout || wdogFire_reg;
            extResetOe_n <= !(wdogTimeout || wdogFire_reg);
        end
    end

    // Checks
    property irq_follows_p;
        @(posedge clk) disable iff (!rstn)
        (clkEn && ovfFlag_reg && ovfEn_reg) |=> irqReq;
    endproperty
    ovf_irq_a: assert property (irq_follows_p) else $error("Overflow request missing");

    per_irq_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && !(perFlag_reg && perEn_reg) && !(ovfFlag_reg && ovfEn_reg)) |=> !irqReq)
        else $error("Spurious request");

    ovf_set_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && ovfEvent && !stopEnter && !extReset && !wdogFire_reg) |=> ovfFlag_reg)
        else $error("Overflow flag not set");

    per_set_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && tapRise && !stopEnter && !extReset && !wdogFire_reg) |=> perFlag_reg)
        else $error("Periodic flag not set");

    ovf_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (wrCtrl && writedata[`MFT_BIT_OVF_CLR] && !ovfEvent) |=> !ovfFlag_reg)
        else $error("Overflow clear failed");

    per_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (wrCtrl && writedata[`MFT_BIT_PER_CLR] && !tapRise) |=> !perFlag_reg)
        else $error("Periodic clear failed");

    sequence stop_seq;
        clkEn && stopEnter;
    endsequence
    stop_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        stop_seq |=> (chain_reg == '0) && !ovfEn_reg && !perEn_reg && !ovfFlag_reg)
        else $error("Stop did not clear");

    wdog_pin_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && wdogTimeout) |=> (!extResetOe_n && coreResetReq))
        else $error("Watchdog reset not driven");

    wdog_srv_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && wdogService && !wdogTimeout) |=> (wdog_reg == 3'h0))
        else $error("Watchdog restart failed");

    count_step_a: assert property (@(posedge clk) disable iff (!rstn)
        (clkEn && running && !stopReq && !extReset && !wdogTimeout) |=> (chain_reg == $past(chainInc)))
        else $error("Chain did not advance");

endmodule
`default_nettype wire

// ### tb/mft_core_model.sv
// Core-side model: reset pin with pull-up and wake counter
`timescale 1ns/1ns
`default_nettype none
module mft_core_model (
    // Device side
    input wire logic clk,
    input wire logic irqReq,
    input wire logic extResetOut,
    input wire logic extResetOe_n,
    // Bench side
    input wire logic pinHold,
    output logic extResetPin_n,
    output int wakeCount
);
    logic irqPrev;
    // Pull-up unless device or bench drives low
    assign extResetPin_n = !extResetOe_n ? extResetOut : !pinHold;
    initial begin
        wakeCount = 0;
        irqPrev = 1'b0;
    end
    // Each new request wakes the core
    always @(posedge clk) begin
        if (irqReq === 1'b1 && !irqPrev) begin
            wakeCount <= wakeCount + 1;
        end
        irqPrev <= (irqReq === 1'b1);
    end
endmodule
`default_nettype wire

// ### tb/multi_function_timer_chain_test.sv
// Bench for the multi-function timer chain
`timescale 1ns/1ns
`default_nettype none
module multi_function_timer_chain_test;
    localparam int POR = 64;
    logic clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, waitrequest, pinHold = 1'b0;
    logic stopReq = 1'b0, stopExit = 1'b0, stopLongDelay = 1'b0;
    logic irqReq, coreResetReq, extResetPin_n, extResetOut, extResetOe_n;
    logic [3:0] address = 4'h0;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0] q, a;
    int n_mismatch = 0, samples_checked = 0, wakeCount;
    time t1;
    always #5 clk = ~clk;
    mft_timer #(.POR_CYCLES(POR)) uut (.clk(clk), .rstn(rstn), .clkEn(1'b1), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
        .stopReq(stopReq), .stopExit(stopExit), .stopLongDelay(stopLongDelay), .irqReq(irqReq),
        .coreResetReq(coreResetReq), .extResetPin_n(extResetPin_n), .extResetOut(extResetOut),
        .extResetOe_n(extResetOe_n));
    mft_core_model core (.clk(clk), .irqReq(irqReq), .extResetOut(extResetOut), .extResetOe_n(extResetOe_n),
        .pinHold(pinHold), .extResetPin_n(extResetPin_n), .wakeCount(wakeCount));
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task bus(input logic wr, input logic [3:0] ad, input logic [7:0] d);
        @(posedge clk);
        address <= ad;
        read <= !wr;
        write <= wr;
        writedata <= {24'h0, d};
        do @(posedge clk); while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask
    task wait_irq(input int lim);
        int i;
        i = 0;
        while (irqReq !== 1'b1 && i < lim) begin
            @(posedge clk);
            i++;
        end
        check("irq arrival", irqReq, 1'b1);
    endtask
    task test_reset;
        repeat (POR - 4) @(posedge clk);
        check("core reset held", coreResetReq, 1'b1);
        repeat (12) @(posedge clk);
        check("core reset released", coreResetReq, 1'b0);
        bus(0, 4'h8, 8'h0);
        check("ctrl reset", q, 8'h03);
        bus(0, 4'h9, 8'h0);
        check("count restarted", q < 8'h08, 1'b1);
        bus(0, 4'ha, 8'h0);
        check("watchdog on", q, 8'h01);
        bus(1, 4'ha, 8'h00);
        bus(0, 4'ha, 8'h0);
        check("watchdog off", q, 8'h00);
        bus(0, 4'h3, 8'h0);
        check("unmapped", q, 8'h00);
    endtask
    task test_count;
        bus(0, 4'h9, 8'h0);
        a = q;
        bus(1, 4'h9, 8'h55);
        repeat (34) @(posedge clk);
        bus(0, 4'h9, 8'h0);
        check("count step", q - a, 8'h0a);
    endtask
    task test_overflow;
        bus(1, 4'h8, 8'h23);
        wait_irq(1100);
        bus(0, 4'h8, 8'h0);
        check("ovf flag", q, 8'ha3);
        bus(1, 4'h8, 8'h63);
        bus(0, 4'h8, 8'h0);
        check("zero clear", q, 8'ha3);
        bus(1, 4'h8, 8'h0b);
        bus(0, 4'h8, 8'h0);
        check("ovf cleared", q, 8'h03);
        check("irq dropped", irqReq, 1'b0);
        repeat (1100) @(posedge clk);
        check("masked ovf", irqReq, 1'b0);
        bus(0, 4'h8, 8'h0);
        check("flag while masked", q, 8'h83);
    endtask
    task test_periodic;
        bus(1, 4'hb, 8'h00);
        bus(1, 4'h8, 8'h1c);
        wait_irq(16400);
        t1 = $time;
        bus(0, 4'h8, 8'h0);
        check("periodic flag", q[6], 1'b1);
        bus(1, 4'h8, 8'h14);
        bus(0, 4'h8, 8'h0);
        check("periodic cleared", q[6], 1'b0);
        wait_irq(16400);
        check("rate 00 period", ($time - t1) / 10, 32'd16384);
        check("wake seen", wakeCount >= 2, 1'b1);
    endtask
    task test_pin;
        pinHold <= 1'b1;
        repeat (6) @(posedge clk);
        pinHold <= 1'b0;
        bus(0, 4'h9, 8'h0);
        check("chain cleared", q < 8'h04, 1'b1);
    endtask
    task test_stop;
        bus(1, 4'h8, 8'h33);
        stopReq <= 1'b1;
        repeat (4) @(posedge clk);
        stopReq <= 1'b0;
        stopExit <= 1'b1;
        @(posedge clk);
        stopExit <= 1'b0;
        repeat (1100) @(posedge clk);
        check("stop irq", irqReq, 1'b0);
        bus(0, 4'h8, 8'h0);
        check("stop clears", q & 8'h3f, 8'h03);
        bus(0, 4'h9, 8'h0);
        check("short recovery", q < 8'h20, 1'b1);
        stopLongDelay <= 1'b1;
        stopReq <= 1'b1;
        repeat (4) @(posedge clk);
        stopReq <= 1'b0;
        stopExit <= 1'b1;
        @(posedge clk);
        stopExit <= 1'b0;
        repeat (100) @(posedge clk);
        bus(0, 4'h9, 8'h0);
        check("long recovery", q < 8'h10, 1'b1);
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        test_reset;
        test_count;
        test_overflow;
        test_periodic;
        test_pin;
        test_stop;
        report_and_stop;
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        report_and_stop;
    end
endmodule
`default_nettype wire
